// >>> hw/pcmc_defs.svh
// Constants for the transceiver configuration and media status block.
// Assumes a byte-addressed register port with 32-bit words.
`ifndef PCMC_DEFS_SVH
`define PCMC_DEFS_SVH

// Register byte addresses
`define PCMC_OFS_CFG 16'h0004
`define PCMC_OFS_ISR 16'h0010
`define PCMC_OFS_IMR 16'h0014

// Field positions in the configuration and media status word
`define PCMC_B_SPEED 30
`define PCMC_B_NEGDN 27
`define PCMC_B_XCFG_HI 23
`define PCMC_B_XCFG_LO 18
`define PCMC_B_AUTOCLR 17
`define PCMC_B_PAUSE 16
`define PCMC_B_MODE_HI 15
`define PCMC_B_MODE_LO 13
`define PCMC_B_EXTSEL 12
`define PCMC_B_XRST 10
`define PCMC_B_PWRDN 9

// Event bits of the interrupt status and mask registers
`define PCMC_NUM_EV 3
`define PCMC_EV_NEGDN 0
`define PCMC_EV_XIRQ 1
`define PCMC_EV_SPEED 2

// Reset values
`define PCMC_XCFG_RST 6'h00
`define PCMC_MODE_RST 3'h0
`define PCMC_MASK_RST 3'h0

`endif

// >>> hw/pcmc_pkg.sv
// Types shared by the transceiver configuration block.
// Assumes pcmc_defs.svh for the numeric constants.
package pcmc_pkg;

    // Negotiation mode select codes
    typedef enum logic [2:0] {
        PCMC_M_F10H = 3'b000,
        PCMC_M_A10 = 3'b001,
        PCMC_M_F100H = 3'b010,
        PCMC_M_A10_100H = 3'b011,
        PCMC_M_F10F = 3'b100,
        PCMC_M_A100 = 3'b101,
        PCMC_M_F100F = 3'b110,
        PCMC_M_AALL = 3'b111
    } pcmc_mode_t;

    // Decoded transceiver behaviour for one mode code
    typedef struct packed {
        logic anegEn;
        logic force100;
        logic forceFull;
        logic adv10Half;
        logic adv10Full;
        logic adv100Half;
        logic adv100Full;
    } pcmc_phymode_t;

    // State of the top module, apart from the interrupt status, mask and irq held in pcmc_irq_ctrl
    typedef struct packed {
        logic [5:0] xcvrCfg;
        logic autoClear;
        logic pauseAdv;
        logic [2:0] modeSel;
        logic extSel;
        logic xcvrRst;
        logic pwrDn;
        logic [1:0] syncDone;
        logic [1:0] syncActive;
        logic [1:0] syncSpeed;
        logic [1:0] syncIrq;
        logic negFlagQ;
        logic speedQ;
        logic xirqQ;
        logic [31:0] rdData;
        logic xcvrIrqClear;
        pcmc_phymode_t phyMode;
        logic advPause;
    } pcmc_state_t;

endpackage

// >>> hw/pcmc_mode_decode.sv
// Decoder from the negotiation mode code to transceiver controls.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module pcmc_mode_decode
    import pcmc_pkg::*;
(
    input wire logic [2:0] modeSel,
    input wire logic pauseAdv,
    output pcmc_phymode_t phyMode,
    output logic advPause
);

    // One entry per code; every 3-bit value is legal
    function automatic pcmc_phymode_t pcmc_decode(input logic [2:0] code);
        pcmc_phymode_t m;
        m = '0;
        unique case (pcmc_mode_t'(code))
            PCMC_M_F10H: m = '0; // [RL8]
            PCMC_M_F100H: m.force100 = 1'b1; // [RL8]
            PCMC_M_F10F: m.forceFull = 1'b1; // [RL9]
            PCMC_M_F100F: begin // [RL9]
                m.force100 = 1'b1;
                m.forceFull = 1'b1;
            end
            PCMC_M_A10: begin // [RL10]
                m.anegEn = 1'b1;
                m.adv10Half = 1'b1;
                m.adv10Full = 1'b1;
            end
            PCMC_M_A10_100H: begin // [RL10]
                m.anegEn = 1'b1;
                m.adv10Half = 1'b1;
                m.adv100Half = 1'b1;
            end
            PCMC_M_A100: begin // [RL11]
                m.anegEn = 1'b1;
                m.adv100Half = 1'b1;
                m.adv100Full = 1'b1;
            end
            PCMC_M_AALL: begin // [RL11]
                m.anegEn = 1'b1;
                m.adv10Half = 1'b1;
                m.adv10Full = 1'b1;
                m.adv100Half = 1'b1;
                m.adv100Full = 1'b1;
            end
        endcase
        return m;
    endfunction

    // Pause rides only on a full-duplex advertisement
    always_comb begin
        phyMode = pcmc_decode(modeSel);
        advPause = pauseAdv & phyMode.anegEn & (phyMode.adv10Full | phyMode.adv100Full); // [RL6]
    end

endmodule
`default_nettype wire

// >>> hw/pcmc_irq_ctrl.sv
// Sticky event status, mask and level interrupt.
// Assumes single-cycle event pulses and read strobes on the same clock.
`timescale 1ns/1ns
`default_nettype none
module pcmc_irq_ctrl #(
    parameter int NUM_EV = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [NUM_EV-1:0] evPulse,
    input wire logic statusRd,
    input wire logic maskWr,
    input wire logic [NUM_EV-1:0] maskData,
    output logic [NUM_EV-1:0] status,
    output logic [NUM_EV-1:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] mask;
        logic irq;
    } pcmc_irq_state_t;

    pcmc_irq_state_t cur;
    pcmc_irq_state_t next_cur;

    // A read clears, but an event in the same cycle survives it
    always_comb begin
        next_cur = cur;
        next_cur.status = (cur.status & ~{NUM_EV{statusRd}}) | evPulse;
        if (maskWr) begin
            next_cur.mask = maskData;
        end
        next_cur.irq = |(next_cur.status & next_cur.mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign status = cur.status;
    assign mask = cur.mask;
    assign irq = cur.irq;

endmodule
`default_nettype wire

// >>> hw/pcmc_top.sv
// Configuration and media status register for the internal transceiver.
// Assumes a plain register port on clk, an EEPROM loader pulsing on clk,
// and transceiver status lines that arrive from outside the clock domain.
//
// Operation
// [RL1] The negotiation done flag reads one when negotiation has finished or is not running.
// [RL2] A six-bit transceiver power-on option field sits in bits 23 to 18.
// [RL3] With auto-clear enabled, each read of the interrupt status clears the transceiver interrupt source.
// [RL4] With auto-clear disabled, software clears the transceiver interrupt through its own registers.
// [RL5] The pause-advertise bit is loaded from EEPROM at power-up and steers pause advertisement.
// [RL6] Pause is advertised only when the negotiation mode also advertises full duplex.
// [RL7] The three-bit negotiation mode is loaded from EEPROM and sets the negotiation default.
// [RL8] Codes 000 and 010 force 10 and 100 Mb/s half duplex without negotiation.
// [RL9] Codes 100 and 110 force 10 and 100 Mb/s full duplex without negotiation.
// [RL10] Codes 001 and 011 negotiate 10 half/full, and 10/100 half only.
// [RL11] Codes 101 and 111 negotiate 100 half/full, and 10/100 half/full.
// [RL12] Selecting the external transceiver enables the MII and sets the power-down bit.
// [RL13] The power-down bit forces the internal transceiver into low power.
// [RL14] The transceiver reset bit holds the transceiver in reset until cleared and reloads options.
// [RL15] The speed flag reads one at 100 Mb/s, forced or negotiated, and zero at 10 Mb/s.
// [RL16] Bits 26 to 24 and bit 11 read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "pcmc_defs.svh"
module pcmc_top
    import pcmc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic irq,
    input wire logic eeLoad,
    input wire logic eePauseAdv,
    input wire logic [2:0] eeModeSel,
    input wire logic phyNegDone,
    input wire logic phyNegActive,
    input wire logic phySpeed100,
    input wire logic phyIrq,
    output logic xcvrIrqClear,
    output logic [5:0] xcvrCfg,
    output logic xcvrAnegEn,
    output logic xcvrForce100,
    output logic xcvrForceFull,
    output logic xcvrAdv10Half,
    output logic xcvrAdv10Full,
    output logic xcvrAdv100Half,
    output logic xcvrAdv100Full,
    output logic xcvrAdvPause,
    output logic xcvrPowerDown,
    output logic xcvrReset,
    output logic miiEnable
);

    pcmc_state_t cur;
    pcmc_state_t next_cur;

    logic cfgSel;
    logic isrSel;
    logic imrSel;
    logic isrRead;
    logic imrWrite;
    logic negFlag;
    logic speedFlag;
    logic [`PCMC_NUM_EV-1:0] evPulse;
    logic [`PCMC_NUM_EV-1:0] evStatus;
    logic [`PCMC_NUM_EV-1:0] evMask;
    logic [`PCMC_NUM_EV-1:0] imrData;
    pcmc_phymode_t decMode;
    logic decPause;

    // Address decode; unmapped addresses read zero and drop writes
    assign cfgSel = (regAddr == `PCMC_OFS_CFG);
    assign isrSel = (regAddr == `PCMC_OFS_ISR);
    assign imrSel = (regAddr == `PCMC_OFS_IMR);
    assign isrRead = regRd & isrSel;
    assign imrWrite = regWr & imrSel;
    assign imrData = regWrData[`PCMC_NUM_EV-1:0];

    // Mode decode works on the stored code; its result is registered below
    pcmc_mode_decode u_decode (
        .modeSel(cur.modeSel),
        .pauseAdv(cur.pauseAdv),
        .phyMode(decMode),
        .advPause(decPause)
    );

    // Status flags seen by software, built from synchronised transceiver lines
    assign negFlag = cur.syncDone[1] | ~cur.phyMode.anegEn | ~cur.syncActive[1]; // [RL1]
    // Forced modes answer from the code, since the transceiver may not report them
    assign speedFlag = cur.phyMode.anegEn ? cur.syncSpeed[1] : cur.phyMode.force100; // [RL15]

    // Events: negotiation finishing, transceiver interrupt rising, speed change
    always_comb begin
        evPulse = '0;
        evPulse[`PCMC_EV_NEGDN] = negFlag & ~cur.negFlagQ;
        evPulse[`PCMC_EV_XIRQ] = cur.syncIrq[1] & ~cur.xirqQ;
        evPulse[`PCMC_EV_SPEED] = speedFlag ^ cur.speedQ;
    end

    pcmc_irq_ctrl #(
        .NUM_EV(`PCMC_NUM_EV)
    ) u_irq (
        .clk(clk),
        .sys_rst(sys_rst),
        .evPulse(evPulse),
        .statusRd(isrRead),
        .maskWr(imrWrite),
        .maskData(imrData),
        .status(evStatus),
        .mask(evMask),
        .irq(irq)
    );

    // Next state of the whole register block
    always_comb begin
        next_cur = cur;

        // Two-flop synchronisers; only the second stage is read elsewhere
        next_cur.syncDone = {cur.syncDone[0], phyNegDone};
        next_cur.syncActive = {cur.syncActive[0], phyNegActive};
        next_cur.syncSpeed = {cur.syncSpeed[0], phySpeed100};
        next_cur.syncIrq = {cur.syncIrq[0], phyIrq};
        next_cur.negFlagQ = negFlag;
        next_cur.speedQ = speedFlag;
        next_cur.xirqQ = cur.syncIrq[1];

        // Software write; reserved and unused bits have no storage
        if (regWr && cfgSel) begin // [RL16]
            next_cur.xcvrCfg = regWrData[`PCMC_B_XCFG_HI:`PCMC_B_XCFG_LO]; // [RL2]
            next_cur.autoClear = regWrData[`PCMC_B_AUTOCLR];
            next_cur.pauseAdv = regWrData[`PCMC_B_PAUSE];
            next_cur.modeSel = regWrData[`PCMC_B_MODE_HI:`PCMC_B_MODE_LO];
            next_cur.extSel = regWrData[`PCMC_B_EXTSEL];
            next_cur.xcvrRst = regWrData[`PCMC_B_XRST]; // [RL14]
            // External transceiver always drags power-down along
            next_cur.pwrDn = regWrData[`PCMC_B_PWRDN] | regWrData[`PCMC_B_EXTSEL]; // [RL12]
        end

        // EEPROM load wins over a software write in the same cycle
        if (eeLoad) begin
            next_cur.pauseAdv = eePauseAdv; // [RL5]
            next_cur.modeSel = eeModeSel; // [RL7]
        end

        // Registered transceiver controls
        next_cur.phyMode = decMode;
        next_cur.advPause = decPause; // [RL6]

        // Auto-clear pulse toward the transceiver; without it software must clear
        next_cur.xcvrIrqClear = isrRead & cur.autoClear; // [RL3]

        // Read data stands only in the cycle after the strobe
        next_cur.rdData = '0;
        if (regRd) begin
            if (cfgSel) begin
                next_cur.rdData[`PCMC_B_SPEED] = speedFlag; // [RL15]
                next_cur.rdData[`PCMC_B_NEGDN] = negFlag; // [RL1]
                next_cur.rdData[`PCMC_B_XCFG_HI:`PCMC_B_XCFG_LO] = cur.xcvrCfg; // [RL2]
                next_cur.rdData[`PCMC_B_AUTOCLR] = cur.autoClear;
                next_cur.rdData[`PCMC_B_PAUSE] = cur.pauseAdv;
                next_cur.rdData[`PCMC_B_MODE_HI:`PCMC_B_MODE_LO] = cur.modeSel;
                next_cur.rdData[`PCMC_B_EXTSEL] = cur.extSel;
                next_cur.rdData[`PCMC_B_XRST] = cur.xcvrRst;
                next_cur.rdData[`PCMC_B_PWRDN] = cur.pwrDn;
            end else if (isrSel) begin
                next_cur.rdData[`PCMC_NUM_EV-1:0] = evStatus;
            end else if (imrSel) begin
                next_cur.rdData[`PCMC_NUM_EV-1:0] = evMask;
            end
        end
    end

    // Single register stage; sys_rst is the only reset that lands here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur <= '0;
            cur.xcvrCfg <= `PCMC_XCFG_RST;
            cur.modeSel <= `PCMC_MODE_RST;
            // Done flag idles high with negotiation off; a low history would fake an event
            cur.negFlagQ <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs come straight from the state register
    assign regRdData = cur.rdData;
    assign xcvrIrqClear = cur.xcvrIrqClear;
    assign xcvrCfg = cur.xcvrCfg;
    assign xcvrAnegEn = cur.phyMode.anegEn;
    assign xcvrForce100 = cur.phyMode.force100;
    assign xcvrForceFull = cur.phyMode.forceFull;
    assign xcvrAdv10Half = cur.phyMode.adv10Half;
    assign xcvrAdv10Full = cur.phyMode.adv10Full;
    assign xcvrAdv100Half = cur.phyMode.adv100Half;
    assign xcvrAdv100Full = cur.phyMode.adv100Full;
    assign xcvrAdvPause = cur.advPause;
    assign xcvrPowerDown = cur.pwrDn; // [RL13]
    // Held until software clears it; options above are what it reloads
    assign xcvrReset = cur.xcvrRst; // [RL14]
    assign miiEnable = cur.extSel; // [RL12]

endmodule
`default_nettype wire

// >>> verification/pcmc_top_assertions.sv
// Port-level checker for the configuration and media status block.
// Assumes it is bound into pcmc_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module pcmc_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic eeLoad,
    input wire logic eePauseAdv,
    input wire logic [2:0] eeModeSel,
    input wire logic xcvrIrqClear,
    input wire logic [5:0] xcvrCfg,
    input wire logic xcvrAnegEn,
    input wire logic xcvrForce100,
    input wire logic xcvrAdvPause,
    input wire logic xcvrPowerDown,
    input wire logic xcvrReset,
    input wire logic miiEnable
);
    logic [2:0] lowCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Cycles with negotiation off, counted up to seven and held there
    always_ff @(posedge clk) begin
        if (sys_rst || xcvrAnegEn) lowCnt <= 3'h0;
        else if (lowCnt != 3'h7) lowCnt <= lowCnt + 3'h1;
    end
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data not zero outside a read");
    a_rsvd_bits: assert property (
        $past(regRd) |-> regRdData[26:24] == 3'h0 && !regRdData[11])
        else $error("reserved bits read nonzero");
    a_autoclr_cause: assert property (
        xcvrIrqClear |-> $past(regRd && regAddr == 16'h0010))
        else $error("irq clear without status read");
    a_ext_pwrdn: assert property (
        regWr && regAddr == 16'h0004 && regWrData[12] |=> xcvrPowerDown && miiEnable)
        else $error("external select did not power down");
    a_cfg_write: assert property (
        regWr && regAddr == 16'h0004
        |=> xcvrCfg == $past(regWrData[23:18]) && xcvrReset == $past(regWrData[10]))
        else $error("config write not applied");
    a_cfg_hold: assert property (!(regWr && regAddr == 16'h0004) |=> $stable(xcvrCfg))
        else $error("option field changed without write");
    a_ee_load: assert property (
        eeLoad |-> ##2 xcvrAnegEn == $past(eeModeSel[0], 2)
        && xcvrAdvPause == $past(eePauseAdv && eeModeSel[0] && eeModeSel != 3'h3, 2))
        else $error("eeprom load decode wrong");
    a_pause_full: assert property (xcvrAdvPause |-> xcvrAnegEn)
        else $error("pause advertised without negotiation");
    a_negdone_off: assert property (
        regRd && regAddr == 16'h0004 && lowCnt == 3'h7 |=> regRdData[27])
        else $error("done flag low while negotiation off");
    a_speed_forced: assert property (
        regRd && regAddr == 16'h0004 && lowCnt == 3'h7
        |=> regRdData[30] == $past(xcvrForce100))
        else $error("forced speed flag wrong");
endmodule
bind pcmc_top pcmc_checker chkInst (.clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .eeLoad, .eePauseAdv, .eeModeSel, .xcvrIrqClear, .xcvrCfg, .xcvrAnegEn,
    .xcvrForce100, .xcvrAdvPause, .xcvrPowerDown, .xcvrReset, .miiEnable);
`default_nettype wire

// >>> verification/pcmc_phy_model.sv
// Behavioural internal transceiver: negotiation timer and interrupt source.
// Assumes its controls come from pcmc_top; its outputs are synced there.
`timescale 1ns/1ns
`default_nettype none
module pcmc_phy_model (
    input wire logic clk,
    input wire logic xcvrReset,
    input wire logic xcvrPowerDown,
    input wire logic xcvrAnegEn,
    input wire logic xcvrAdv100Half,
    input wire logic xcvrAdv100Full,
    input wire logic xcvrIrqClear,
    input wire logic raiseIrq,
    input wire logic manualClr,
    output logic phyNegDone,
    output logic phyNegActive,
    output logic phySpeed100,
    output logic phyIrq
);
    logic [3:0] negCnt = 4'h0;
    logic [1:0] advSeen = 2'h0;
    initial begin
        {phyNegDone, phyNegActive, phySpeed100, phyIrq} = 4'h0;
    end
    // A change in the 100 Mb/s advertisement restarts negotiation, as a real link would
    always @(posedge clk) begin
        advSeen <= {xcvrAdv100Half, xcvrAdv100Full};
        if (xcvrReset || xcvrPowerDown || !xcvrAnegEn ||
            advSeen != {xcvrAdv100Half, xcvrAdv100Full}) begin
            negCnt <= 4'h0;
            phyNegActive <= 1'b0;
            phyNegDone <= 1'b0;
            phySpeed100 <= 1'b0;
        end else if (negCnt != 4'h8) begin
            negCnt <= negCnt + 4'h1;
            phyNegActive <= 1'b1;
        end else begin
            phyNegDone <= 1'b1;
            phySpeed100 <= |advSeen;
        end
    end
    // Source stays up until auto-clear or a clear through its own registers
    always @(posedge clk) begin
        if (raiseIrq) phyIrq <= 1'b1;
        else if (xcvrIrqClear || manualClr) phyIrq <= 1'b0;
    end
endmodule
`default_nettype wire

// >>> verification/test_phy_config_media_control.sv
// Self-checking bench for the configuration and media status block.
// Assumes the transceiver model and the bound checker beside pcmc_top.
`timescale 1ns/1ns
`default_nettype none
module test_phy_config_media_control;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic eeLoad = 1'b0;
    logic eePauseAdv = 1'b0;
    logic raiseIrq = 1'b0;
    logic manualClr = 1'b0;
    logic [15:0] regAddr = 16'h0;
    logic [31:0] regWrData = 32'h0;
    logic [2:0] eeModeSel = 3'h0;
    logic [31:0] regRdData, d, e;
    logic [5:0] xcvrCfg;
    logic [7:0] m;
    logic irq, xcvrIrqClear, xcvrAnegEn, xcvrForce100, xcvrForceFull, xcvrAdv10Half;
    logic xcvrAdv10Full, xcvrAdv100Half, xcvrAdv100Full, xcvrAdvPause, xcvrPowerDown;
    logic xcvrReset, miiEnable, phyNegDone, phyNegActive, phySpeed100, phyIrq;
    int bad_count = 0;
    int cmp_count = 0;
    // Row: mode code, then anegEn force100 forceFull adv10H adv10F adv100H adv100F pause
    logic [10:0] rows [8] = '{{3'h0, 8'h00}, {3'h1, 8'h99}, {3'h2, 8'h40}, {3'h3, 8'h94},
        {3'h4, 8'h20}, {3'h5, 8'h87}, {3'h6, 8'h60}, {3'h7, 8'h9F}};
    wire logic [7:0] dec = {xcvrAnegEn, xcvrForce100, xcvrForceFull, xcvrAdv10Half,
        xcvrAdv10Full, xcvrAdv100Half, xcvrAdv100Full, xcvrAdvPause};
    pcmc_top dut (.clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .irq,
        .eeLoad, .eePauseAdv, .eeModeSel, .phyNegDone, .phyNegActive, .phySpeed100, .phyIrq,
        .xcvrIrqClear, .xcvrCfg, .xcvrAnegEn, .xcvrForce100, .xcvrForceFull, .xcvrAdv10Half,
        .xcvrAdv10Full, .xcvrAdv100Half, .xcvrAdv100Full, .xcvrAdvPause, .xcvrPowerDown,
        .xcvrReset, .miiEnable);
    pcmc_phy_model phy (.clk, .xcvrReset, .xcvrPowerDown, .xcvrAnegEn, .xcvrAdv100Half,
        .xcvrAdv100Full, .xcvrIrqClear, .raiseIrq, .manualClr, .phyNegDone, .phyNegActive,
        .phySpeed100, .phyIrq);
    always #25 clk = ~clk;
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bus cycles: strobes one cycle, read data taken in the following cycle
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        v = regRdData;
    endtask
    task automatic eeLd(input logic [2:0] c, input logic p);
        @(posedge clk);
        eeLoad <= 1'b1;
        eeModeSel <= c;
        eePauseAdv <= p;
        @(posedge clk);
        eeLoad <= 1'b0;
    endtask
    task automatic pulse(input logic clr);
        @(posedge clk);
        if (clr) manualClr <= 1'b1;
        else raiseIrq <= 1'b1;
        @(posedge clk);
        manualClr <= 1'b0;
        raiseIrq <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        idle(3000);
        bad_count++;
        give_verdict();
    end
    initial begin
        idle(2);
        sys_rst <= 1'b0;
        idle(4);
        rd(16'h0004, d);
        chk("cfg reset", 32'h08000000, d);
        chk("outs reset", 32'h0, 32'({xcvrCfg, xcvrPowerDown, xcvrReset, miiEnable, irq}));
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            eeLd(rows[i][10:8], 1'b1);
            idle(3);
            m = rows[i][7] ? 8'h9F : 8'hE1;
            chk("decode", 32'(rows[i][7:0] & m), 32'(dec & m));
            idle(20);
            rd(16'h0004, d);
            e = {26'h0, rows[i][7] ? |rows[i][2:1] : rows[i][6], 2'h3, rows[i][10:8]};
            chk("flags", e, {26'h0, d[30], d[27], d[16:13]});
        end
        $display("test modes done");
        wr(16'h0004, 32'hFFFFFFFF);
        rd(16'h0004, d);
        chk("cfg rw", 32'h00FFF600, d & 32'h07FFFE00);
        chk("cfg outs", 32'h1FF, 32'({xcvrCfg, xcvrPowerDown, xcvrReset, miiEnable}));
        wr(16'h0004, 32'h00001000);
        rd(16'h0004, d);
        chk("ext sel", 32'h9, 32'(d[12:9]));
        wr(16'h0100, 32'hFFFFFFFF);
        rd(16'h0100, d);
        chk("unmapped", 32'h0, d);
        $display("test cfg done");
        wr(16'h0014, 32'h2);
        wr(16'h0004, 32'h0002E000);
        rd(16'h0010, d);
        pulse(1'b0);
        idle(8);
        chk("irq up", 32'h1, 32'(irq));
        rd(16'h0010, d);
        chk("isr", 32'h1, 32'(d[1]));
        idle(4);
        chk("autoclr", 32'h0, 32'({irq, phyIrq}));
        wr(16'h0004, 32'h0000E000);
        pulse(1'b0);
        idle(8);
        rd(16'h0010, d);
        idle(4);
        chk("no autoclr", 32'h1, 32'({irq, phyIrq}));
        pulse(1'b1);
        idle(2);
        chk("manual clr", 32'h0, 32'(phyIrq));
        wr(16'h0014, 32'h0);
        pulse(1'b0);
        idle(8);
        chk("masked", 32'h0, 32'(irq));
        rd(16'h0010, d);
        chk("isr masked", 32'h1, 32'(d[1]));
        $display("test irq done");
        // Reset in mid-run, transceiver interrupt still high; no false done event may follow
        idle(1);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        idle(4);
        rd(16'h0004, d);
        chk("cfg rerst", 32'h08000000, d);
        chk("outs rerst", 32'h0, 32'({xcvrCfg, xcvrPowerDown, xcvrReset, miiEnable, irq, dec}));
        rd(16'h0010, d);
        chk("isr rerst", 32'h0, 32'(d[0]));
        $display("test reset again done");
        give_verdict();
    end
endmodule
`default_nettype wire
